//--- hdl/asma_aggregator.sv
// alarm status, mask and combined alarm of the converter core
//
// Summary of operation
// - set lane buffer error flag, bit 5, on overflow or underflow of an active lane
// - set pll unlock flag, bit 4, while the pll is out of lock
// - 8b/10b: set link error flag, bit 3, while enabled link is out of data state
// - 64b/66b: set link error flag at link start-up and on any realignment
// - set realign flag, bit 2, whenever sysref realigns the internal clocks
// - set oscillator flag, bit 1, on link disabled, oscillator sync or phase mismatch
// - set divider mismatch flag, bit 0, when channel dividers disagree
// - writing one clears only that status flag; zeros leave flags alone
// - power-on or soft reset sets all six status flags, value 0x3f
// - with link disabled all flags but bit 0 mean nothing; clear after enabling
// - mask bit n stops status flag n from reaching the combined alarm
// - mask register resets to 0x3f on power-on reset only, all sources masked; soft reset keeps it
// - keep one sticky error bit per lane for sixteen lanes
// - clearing the lane buffer error flag clears all per-lane error bits
`timescale 1ns/1ps
`default_nettype none
`include "asma_defs.svh"

module asma_aggregator #(
    parameter int LANES = `ASMA_LANES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [LANES-1:0] lane_active,
    input wire logic [LANES-1:0] lane_buffer_fault,
    input wire logic pll_locked,
    input wire logic serial_link_enable,
    input wire logic link_mode_66b,
    input wire logic link_in_data_state,
    input wire logic link_realign_event,
    input wire logic sysref_realign_event,
    input wire logic osc_sync_event,
    input wire logic osc_phase_mismatch,
    input wire logic divider_mismatch,
    output logic alarm
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // address compare reused for every register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    asma_pkg::asma_top_s st;
    asma_pkg::asma_top_s next_st;
    logic [LANES-1:0] lane_err;
    logic [15:0] lanes;
    logic wr_status;
    logic wr_mask;
    logic wr_lane_lo;
    logic wr_lane_hi;
    logic clear_lanes;
    logic [5:0] events;

    assign wr_status = reg_wr & hit(reg_addr, `ASMA_ADDR_STATUS);
    assign wr_mask = reg_wr & hit(reg_addr, `ASMA_ADDR_MASK);
    assign wr_lane_lo = reg_wr & hit(reg_addr, `ASMA_ADDR_LANE_LO);
    assign wr_lane_hi = reg_wr & hit(reg_addr, `ASMA_ADDR_LANE_HI);
    // inactive lanes may sit in fault and must not raise alarms
    assign lane_err = lane_buffer_fault & lane_active;
    assign clear_lanes = wr_status & reg_wdata[`ASMA_BIT_LANE_BUFFER];

    ////////////////////////////////////////////////////////////////////////////
    // per-lane errors

    asma_lane_errors #(
        .LANES(LANES)
    ) u_lanes (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .soft_reset(soft_reset),
        .lane_err(lane_err),
        .wr_lo(wr_lane_lo),
        .wr_hi(wr_lane_hi),
        .wdata(reg_wdata),
        .clear_all(clear_lanes),
        .per_lane_buffer_errors(lanes)
    );

    ////////////////////////////////////////////////////////////////////////////
    // alarm sources

    // flags are only meaningful with the link up; they are still driven
    // when it is down so software sees a defined value
    always_comb begin
        events = 6'h00;
        events[`ASMA_BIT_LANE_BUFFER] = |lane_err;
        events[`ASMA_BIT_PLL_UNLOCK] = ~pll_locked;
        if (link_mode_66b) begin
            events[`ASMA_BIT_LINK_STATE] = (serial_link_enable & ~st.link_enable_prev)
                | link_realign_event;
        end else begin
            events[`ASMA_BIT_LINK_STATE] = serial_link_enable & ~link_in_data_state;
        end
        events[`ASMA_BIT_CLOCK_REALIGN] = sysref_realign_event;
        events[`ASMA_BIT_OSC_UPSET] = ~serial_link_enable | osc_sync_event
            | osc_phase_mismatch;
        events[`ASMA_BIT_DIVIDER] = divider_mismatch;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_comb begin
        next_st = st;
        next_st.link_enable_prev = serial_link_enable;
        // write-one-to-clear, and a same-cycle event wins over the clear
        if (wr_status) begin
            next_st.alarm_status_flags = st.alarm_status_flags & ~reg_wdata[5:0];
        end
        next_st.alarm_status_flags = next_st.alarm_status_flags | events;
        if (wr_mask) begin
            next_st.alarm_source_mask = reg_wdata[5:0];
        end
        if (soft_reset) begin
            next_st.alarm_status_flags = `ASMA_STATUS_RESET;
        end
        // computed from next values so alarm tracks the flags without lag
        next_st.alarm = |(next_st.alarm_status_flags & ~next_st.alarm_source_mask);
        // read data lands one cycle after the read strobe
        if (reg_rd) begin
            next_st.rdata = 8'h00;
            if (hit(reg_addr, `ASMA_ADDR_ALARM)) begin
                next_st.rdata = {7'h00, st.alarm};
            end else if (hit(reg_addr, `ASMA_ADDR_STATUS)) begin
                next_st.rdata = {2'h0, st.alarm_status_flags};
            end else if (hit(reg_addr, `ASMA_ADDR_MASK)) begin
                next_st.rdata = {2'h0, st.alarm_source_mask};
            end else if (hit(reg_addr, `ASMA_ADDR_LANE_LO)) begin
                next_st.rdata = lanes[7:0];
            end else if (hit(reg_addr, `ASMA_ADDR_LANE_HI)) begin
                next_st.rdata = lanes[15:8];
            end
        end
    end

    // mask keeps its value over soft reset; only power-on reset restores it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st.alarm_status_flags <= `ASMA_STATUS_RESET;
            st.alarm_source_mask <= `ASMA_MASK_RESET;
            st.link_enable_prev <= 1'b0;
            st.alarm <= 1'b0;
            st.rdata <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign alarm = st.alarm;

endmodule // asma_aggregator
`default_nettype wire

//--- hdl/asma_defs.svh
// register offsets, field positions and reset values of the alarm aggregator
`ifndef ASMA_DEFS_SVH
`define ASMA_DEFS_SVH

`define ASMA_ADDR_W 12
`define ASMA_DATA_W 8
`define ASMA_FLAG_W 6
`define ASMA_LANES 16

`define ASMA_ADDR_ALARM 12'h2c0
`define ASMA_ADDR_STATUS 12'h2c1
`define ASMA_ADDR_MASK 12'h2c2
`define ASMA_ADDR_LANE_LO 12'h2c4
`define ASMA_ADDR_LANE_HI 12'h2c5

`define ASMA_BIT_LANE_BUFFER 5
`define ASMA_BIT_PLL_UNLOCK 4
`define ASMA_BIT_LINK_STATE 3
`define ASMA_BIT_CLOCK_REALIGN 2
`define ASMA_BIT_OSC_UPSET 1
`define ASMA_BIT_DIVIDER 0

`define ASMA_STATUS_RESET 6'h3f
`define ASMA_MASK_RESET 6'h3f
`define ASMA_LANE_RESET 16'hffff

`endif

//--- hdl/asma_lane_errors.sv
// per-lane sticky buffer error register with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
`include "asma_defs.svh"

module asma_lane_errors #(
    parameter int LANES = `ASMA_LANES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic [LANES-1:0] lane_err,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic clear_all,
    output logic [15:0] per_lane_buffer_errors
);

    // the register map has room for sixteen lanes only
    if (LANES < 1 || LANES > 16) begin : g_bad_lanes
        $error("asma_lane_errors: LANES must be 1 to 16");
    end

    asma_pkg::asma_lane_s st;
    asma_pkg::asma_lane_s next_st;
    logic [15:0] err_ext;
    logic [15:0] clr;

    assign err_ext = 16'(lane_err);

    // clear mask from both byte writes and from the summary flag clear
    always_comb begin
        clr = 16'h0000;
        if (wr_lo) begin
            clr[7:0] = wdata;
        end
        if (wr_hi) begin
            clr[15:8] = wdata;
        end
        if (clear_all) begin
            clr = 16'hffff;
        end
    end

    // a fresh error in the clearing cycle survives: set beats clear
    always_comb begin
        next_st = st;
        for (int i = 0; i < 16; i++) begin
            next_st.per_lane_buffer_errors[i] =
                (st.per_lane_buffer_errors[i] & ~clr[i]) | err_ext[i];
        end
        if (soft_reset) begin
            next_st.per_lane_buffer_errors = `ASMA_LANE_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st.per_lane_buffer_errors <= `ASMA_LANE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign per_lane_buffer_errors = st.per_lane_buffer_errors;

endmodule // asma_lane_errors
`default_nettype wire

//--- hdl/asma_pkg.sv
// types shared by the alarm aggregator modules
package asma_pkg;

    // whole state of the aggregator top
    typedef struct packed {
        logic [5:0] alarm_status_flags;
        logic [5:0] alarm_source_mask;
        logic link_enable_prev;
        logic alarm;
        logic [7:0] rdata;
    } asma_top_s;

    // whole state of the per-lane error register
    typedef struct packed {
        logic [15:0] per_lane_buffer_errors;
    } asma_lane_s;

endpackage

//--- sim/asma_aggregator_chk.sv
// concurrent checks on the ports of the alarm aggregator
`timescale 1ns/1ps
`default_nettype none
module asma_aggregator_chk #(
    parameter int LANES = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [LANES-1:0] lane_active,
    input wire logic [LANES-1:0] lane_buffer_fault,
    input wire logic pll_locked,
    input wire logic serial_link_enable,
    input wire logic link_mode_66b,
    input wire logic link_in_data_state,
    input wire logic sysref_realign_event,
    input wire logic divider_mismatch,
    input wire logic alarm
);
    // status read right after a cause; set wins over a clear, so no write can hide it
    wire logic rd_st = reg_rd && reg_addr == 12'h2c1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_lane_flag: assert property (
        |(lane_buffer_fault & lane_active) ##1 rd_st |=> reg_rdata[5]) else $error("lane flag");
    chk_pll_flag: assert property (
        !pll_locked ##1 rd_st |=> reg_rdata[4]) else $error("pll flag");
    chk_link_flag: assert property (
        serial_link_enable && !link_mode_66b && !link_in_data_state ##1 rd_st |=> reg_rdata[3])
        else $error("link flag");
    chk_realign_flag: assert property (
        sysref_realign_event ##1 rd_st |=> reg_rdata[2]) else $error("realign flag");
    chk_osc_flag: assert property (
        !serial_link_enable ##1 rd_st |=> reg_rdata[1]) else $error("osc flag");
    chk_divider_flag: assert property (
        divider_mismatch ##1 rd_st |=> reg_rdata[0]) else $error("divider flag");
    chk_soft_preset: assert property (
        soft_reset && !reg_wr ##1 rd_st |=> reg_rdata[5:0] == 6'h3f) else $error("soft preset");
    chk_reset_masked: assert property (
        $rose(rstn) && !reg_wr |=> !alarm) else $error("alarm after reset");
    chk_full_mask: assert property (
        reg_wr && reg_addr == 12'h2c2 && reg_wdata[5:0] == 6'h3f |=> !alarm) else $error("masked");
endmodule // asma_aggregator_chk
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the alarm aggregator with a status and mask model
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'h0, rstn = 1'h0, soft_reset = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic pll_locked = 1'h1, serial_link_enable = 1'h1, link_mode_66b = 1'h0;
    logic link_in_data_state = 1'h1, link_realign_event = 1'h0, sysref_realign_event = 1'h0;
    logic osc_sync_event = 1'h0, osc_phase_mismatch = 1'h0, divider_mismatch = 1'h0, alarm;
    logic [11:0] reg_addr = 12'h0;
    logic [7:0] reg_wdata = 8'h0, reg_rdata;
    logic [15:0] lane_active = 16'hffff, lane_buffer_fault = 16'h0;
    logic [31:0] seed = 32'h53ac623d;
    int n_fail = 0, tests_run = 0, st = 63, mk = 63, ln = 65535, k;
    asma_aggregator dut_u (.ref_clk, .rstn, .soft_reset, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .lane_active, .lane_buffer_fault, .pll_locked,
        .serial_link_enable, .link_mode_66b, .link_in_data_state, .link_realign_event,
        .sysref_realign_event, .osc_sync_event, .osc_phase_mismatch, .divider_mismatch, .alarm);
    // free-running core clock
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    // xorshift step for the random lane choice
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r ^= r >> 17;
        r ^= r << 5;
        return r;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pulse inputs drop back to quiet with the next register read; writes leave them as they are
    task automatic rest;
        lane_buffer_fault <= 16'h0;
        lane_active <= 16'hffff;
        {pll_locked, link_in_data_state, serial_link_enable} <= 3'h7;
        {soft_reset, sysref_realign_event, osc_sync_event} <= 3'h0;
        {divider_mismatch, link_realign_event, osc_phase_mismatch} <= 3'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        if (a == 12'h2c1) st &= ~int'(d[5:0]);
        if (a == 12'h2c1 && d[5]) ln = 0;
        if (a == 12'h2c2) mk = int'(d[5:0]);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        {reg_addr, reg_rd} <= {a, 1'h1};
        rest;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task automatic al;
        @(negedge ref_clk);
        chk({7'h0, alarm}, 8'((st & ~mk & 63) != 0));
        rd(12'h2c0, 8'((st & ~mk & 63) != 0));
    endtask
    // one cycle of a cause, read back on the very next cycle
    task automatic ev(input int b);
        @(posedge ref_clk);
        case (b)
            5: {lane_buffer_fault, lane_active} <= {16'(3 << k), ~16'(2 << k)};
            4: pll_locked <= 1'h0;
            3: link_in_data_state <= 1'h0;
            2: sysref_realign_event <= 1'h1;
            1: serial_link_enable <= 1'h0;
            default: divider_mismatch <= 1'h1;
        endcase
        st |= 1 << b;
        if (b == 5) ln |= 1 << k;
        rd(12'h2c1, 8'(st));
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence; every wait has a fixed length, so no hang is possible
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'h1;
        rd(12'h2c1, 8'h3f);
        rd(12'h2c2, 8'h3f);
        rd(12'h2c5, 8'hff);
        al;
        wr(12'h2c1, 8'hff);
        rd(12'h2c1, 8'h00);
        rd(12'h2c5, 8'h00);
        for (int b = 0; b < 6; b++) begin
            seed = xs(seed);
            k = int'(seed[3:0]) % 15;
            ev(b);
            rd(12'h2c4, 8'(ln));
            rd(12'h2c5, 8'(ln >> 8));
            al;
            wr(12'h2c2, 8'(63 ^ (1 << b)));
            al;
            wr(12'h2c1, 8'(63 ^ (1 << b)));
            rd(12'h2c1, 8'(st));
            wr(12'h2c1, 8'(1 << b));
            rd(12'h2c4, 8'(ln));
            al;
        end
        @(posedge ref_clk);
        {link_mode_66b, serial_link_enable} <= 2'h2;
        @(posedge ref_clk);
        serial_link_enable <= 1'h1;
        st = 10;
        rd(12'h2c1, 8'h0a);
        wr(12'h2c1, 8'h0a);
        @(posedge ref_clk);
        {link_realign_event, osc_sync_event, osc_phase_mismatch} <= 3'h7;
        st = 10;
        rd(12'h2c1, 8'h0a);
        wr(12'h2c2, 8'h15);
        @(posedge ref_clk);
        soft_reset <= 1'h1;
        st = 63;
        ln = 65535;
        rd(12'h2c1, 8'h3f);
        rd(12'h2c4, 8'hff);
        rd(12'h2c2, 8'h15);
        al;
        // mid-run power-on reset brings the mask back, unlike soft reset
        @(posedge ref_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'h1;
        st = 63;
        mk = 63;
        ln = 65535;
        rd(12'h2c2, 8'h3f);
        rd(12'h2c1, 8'h3f);
        al;
        wr(12'h2c2, 8'h3f);
        rd(12'h2c3, 8'h00);
        stop_test;
    end
endmodule // tb
bind asma_aggregator asma_aggregator_chk #(.LANES(LANES)) chk_u (.ref_clk, .rstn, .soft_reset,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .lane_active, .lane_buffer_fault,
    .pll_locked, .serial_link_enable, .link_mode_66b, .link_in_data_state,
    .sysref_realign_event, .divider_mismatch, .alarm);
`default_nettype wire
